//--- rtl/wcat_defs.vh
`ifndef WCAT_DEFS_VH
`define WCAT_DEFS_VH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define WCAT_ADR_CTRL 8'h00
`define WCAT_ADR_CAUSE 8'h04
`define WCAT_ADR_CORE 8'h08
`define WCAT_ADR_ISTAT 8'h0c
`define WCAT_ADR_ICLR 8'h10
`define WCAT_ADR_IEN 8'h14
`define WCAT_ADR_VEC 8'h18
// ----------------------------------------------------------------
// control/status fields
// ----------------------------------------------------------------
`define WCAT_B_IRQ_FLAG 7
`define WCAT_B_IRQ_EN 6
`define WCAT_B_SEL3 5
`define WCAT_B_UNLOCK 4
`define WCAT_B_RST_EN 3
`define WCAT_B_SEL_HI 2
`define WCAT_B_SEL_LO 0
`define WCAT_B_CAUSE 3
`define WCAT_B_VTSEL 1
`define WCAT_B_EV_TMO 0
`define WCAT_B_EV_RST 1
`define WCAT_NEV 2
// ----------------------------------------------------------------
// timing and encodings
// ----------------------------------------------------------------
`define WCAT_UNLOCK_CYCLES 3'd4
`define WCAT_SEL_MAX 4'h9
`define WCAT_TMO_BASE 2048
`define WCAT_CNT_W 21
`define WCAT_VEC_WDT 16'h0019
`define WCAT_VEC_RESET 16'h0000
`define WCAT_BOOT_START 16'h0c00
`define WCAT_SYNC_DEPTH 3
`endif

//--- rtl/wcat_sync.v
`timescale 1ns/10ps
`include "wcat_defs.vh"
// three-stage synchroniser; the level only moves when stages two and three agree
module wcat_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  input wire clk_i,
  input wire rst_i,
  input wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] level_o
);
  reg [WIDTH-1:0] s1_r;
  reg [WIDTH-1:0] s2_r;
  reg [WIDTH-1:0] s3_r;
  reg [WIDTH-1:0] level_r;
  integer k;

  always @(posedge clk_i) begin
    if (rst_i) begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
      level_r <= INIT;
    end else begin
      s1_r <= async_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (k = 0; k < WIDTH; k = k + 1) begin
        if (s2_r[k] == s3_r[k]) begin
          level_r[k] <= s3_r[k];
        end
      end
    end
  end

  assign level_o = level_r;
endmodule // wcat_sync

//--- rtl/wcat_top.v
// Implementation choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/10ps
`include "wcat_defs.vh"
module wcat_top #(
  parameter TMO_BASE = `WCAT_TMO_BASE,
  parameter [15:0] BOOT_START = `WCAT_BOOT_START
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  input wire wdt_osc_i,
  input wire always_on_fuse_n_i,
  input wire boot_reset_fuse_n_i,
  input wire restart_i,
  input wire vector_taken_i,
  output wire timeout_irq_req_o,
  output wire sys_reset_o,
  output wire [15:0] reset_vector_o,
  output wire [15:0] timeout_vector_o,
  output wire irq_o
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg ack_r;
  reg [31:0] dat_r;
  reg irq_flag_r;
  reg irq_en_r;
  reg rst_en_r;
  reg [3:0] sel_r;
  reg unlock_r;
  reg [2:0] unlock_cnt_r;
  reg cause_r;
  reg vtsel_r;
  reg [`WCAT_NEV-1:0] ev_stat_r;
  reg [`WCAT_NEV-1:0] ev_en_r;
  reg [`WCAT_CNT_W-1:0] cnt_r;
  reg osc_prev_r;
  reg sys_reset_r;
  reg [15:0] rst_vec_r;
  reg [15:0] tmo_vec_r;
  wire osc_lvl;
  wire fuse_on_n;
  wire boot_n;
  wire [2:0] sync_lvl;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // fuses idle unprogrammed (high) so nothing is forced during reset
  wcat_sync #(
    .WIDTH(3),
    .INIT(3'b110)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({boot_reset_fuse_n_i, always_on_fuse_n_i, wdt_osc_i}),
    .level_o(sync_lvl)
  );
  assign osc_lvl = sync_lvl[0];
  assign fuse_on_n = sync_lvl[1];
  assign boot_n = sync_lvl[2];

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // reserved codes clamp to the longest period rather than wrap short
  function [`WCAT_CNT_W-1:0] tmo_limit;
    input [3:0] sel;
    reg [3:0] s;
    begin
      s = (sel > `WCAT_SEL_MAX) ? `WCAT_SEL_MAX : sel;
      tmo_limit = TMO_BASE[`WCAT_CNT_W-1:0] << s;
    end
  endfunction

  function [3:0] sel_of;
    input [7:0] d;
    begin
      sel_of = {d[`WCAT_B_SEL3], d[`WCAT_B_SEL_HI:`WCAT_B_SEL_LO]};
    end
  endfunction

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire req = wb_cyc_i & wb_stb_i & ~ack_r;
  wire wr = req & wb_we_i & wb_sel_i[0];
  wire wr_ctrl = wr && (wb_adr_i == `WCAT_ADR_CTRL);
  wire wr_cause = wr && (wb_adr_i == `WCAT_ADR_CAUSE);
  wire wr_core = wr && (wb_adr_i == `WCAT_ADR_CORE);
  wire wr_iclr = wr && (wb_adr_i == `WCAT_ADR_ICLR);
  wire wr_ien = wr && (wb_adr_i == `WCAT_ADR_IEN);
  wire [7:0] wd = wb_dat_i[7:0];

  // effective configuration
  wire fuse_on = ~fuse_on_n;
  wire rst_en_eff = rst_en_r | cause_r | fuse_on;
  wire irq_en_eff = irq_en_r & ~fuse_on;
  wire running = rst_en_eff | irq_en_eff;
  wire tick = osc_lvl & ~osc_prev_r;
  wire [`WCAT_CNT_W-1:0] cnt_inc = cnt_r + 1'b1;
  wire expire = running & tick & (cnt_inc >= tmo_limit(sel_r));
  // interrupt mode, or first time-out of interrupt-then-reset mode
  wire tmo_irq = expire & irq_en_eff & ~(rst_en_eff & irq_flag_r);
  wire tmo_rst = expire & rst_en_eff & ~tmo_irq;
  wire [`WCAT_NEV-1:0] ev_set = {tmo_rst, tmo_irq};

  // ----------------------------------------------------------------
  // watchdog counter
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= {`WCAT_CNT_W{1'b0}};
      osc_prev_r <= 1'b0;
      sys_reset_r <= 1'b0;
    end else begin
      osc_prev_r <= osc_lvl;
      sys_reset_r <= tmo_rst;
      if (restart_i || !running || expire) begin
        cnt_r <= {`WCAT_CNT_W{1'b0}};
      end else if (tick) begin
        cnt_r <= cnt_inc;
      end
    end
  end

  // ----------------------------------------------------------------
  // control/status register
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_flag_r <= 1'b0;
      irq_en_r <= 1'b0;
      rst_en_r <= 1'b0;
      sel_r <= 4'h0;
      unlock_r <= 1'b0;
      unlock_cnt_r <= 3'd0;
    end else begin
      // time-out set beats a write-one clear in the same cycle
      if (tmo_irq) begin
        irq_flag_r <= 1'b1;
      end else if (vector_taken_i && irq_flag_r) begin
        irq_flag_r <= 1'b0;
      end else if (wr_ctrl && wd[`WCAT_B_IRQ_FLAG]) begin
        irq_flag_r <= 1'b0;
      end
      if (vector_taken_i && irq_flag_r && rst_en_eff) begin
        irq_en_r <= 1'b0; // drop to reset mode after the vector
      end else if (wr_ctrl) begin
        irq_en_r <= wd[`WCAT_B_IRQ_EN];
      end
      if (wr_ctrl && unlock_r && !wd[`WCAT_B_UNLOCK]) begin
        rst_en_r <= wd[`WCAT_B_RST_EN];
        sel_r <= sel_of(wd);
        unlock_r <= 1'b0;
        unlock_cnt_r <= 3'd0;
      end else if (wr_ctrl && wd[`WCAT_B_UNLOCK]) begin
        // a one can always be written; clearing needs the unlock
        rst_en_r <= rst_en_r | wd[`WCAT_B_RST_EN];
        if (unlock_r) begin
          sel_r <= sel_of(wd);
        end
        unlock_r <= 1'b1;
        unlock_cnt_r <= 3'd0;
      end else begin
        if (wr_ctrl) begin
          rst_en_r <= rst_en_r | wd[`WCAT_B_RST_EN];
        end
        if (unlock_r) begin
          if (unlock_cnt_r == `WCAT_UNLOCK_CYCLES - 3'd1) begin
            unlock_r <= 1'b0;
            unlock_cnt_r <= 3'd0;
          end else begin
            unlock_cnt_r <= unlock_cnt_r + 3'd1;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // reset cause, core control and vectors
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      cause_r <= 1'b0;
      vtsel_r <= 1'b0;
      rst_vec_r <= `WCAT_VEC_RESET;
      tmo_vec_r <= `WCAT_VEC_WDT;
    end else begin
      // watchdog reset beats a software clear (write zero)
      if (tmo_rst) begin
        cause_r <= 1'b1;
      end else if (wr_cause && !wd[`WCAT_B_CAUSE]) begin
        cause_r <= 1'b0;
      end
      if (wr_core) begin
        vtsel_r <= wd[`WCAT_B_VTSEL];
      end
      rst_vec_r <= boot_n ? `WCAT_VEC_RESET : BOOT_START;
      tmo_vec_r <= vtsel_r ? (`WCAT_VEC_WDT + BOOT_START) : `WCAT_VEC_WDT;
    end
  end

  // ----------------------------------------------------------------
  // bus event interrupt
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      ev_stat_r <= {`WCAT_NEV{1'b0}};
      ev_en_r <= {`WCAT_NEV{1'b0}};
    end else begin
      if (wr_iclr) begin
        ev_stat_r <= (ev_stat_r & ~wd[`WCAT_NEV-1:0]) | ev_set;
      end else begin
        ev_stat_r <= ev_stat_r | ev_set;
      end
      if (wr_ien) begin
        ev_en_r <= wd[`WCAT_NEV-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= req;
      dat_r <= 32'h0000_0000;
      if (req && !wb_we_i) begin
        if (wb_adr_i == `WCAT_ADR_CTRL) begin
          // the fuse locks the interrupt enable low, so show what acts
          dat_r[7:0] <= {irq_flag_r, irq_en_eff, sel_r[3], unlock_r, rst_en_eff, sel_r[2:0]};
        end else if (wb_adr_i == `WCAT_ADR_CAUSE) begin
          dat_r[`WCAT_B_CAUSE] <= cause_r;
        end else if (wb_adr_i == `WCAT_ADR_CORE) begin
          dat_r[`WCAT_B_VTSEL] <= vtsel_r;
        end else if (wb_adr_i == `WCAT_ADR_ISTAT) begin
          dat_r[`WCAT_NEV-1:0] <= ev_stat_r;
        end else if (wb_adr_i == `WCAT_ADR_IEN) begin
          dat_r[`WCAT_NEV-1:0] <= ev_en_r;
        end else if (wb_adr_i == `WCAT_ADR_VEC) begin
          dat_r <= {tmo_vec_r, rst_vec_r};
        end
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign timeout_irq_req_o = irq_flag_r & irq_en_eff;
  assign sys_reset_o = sys_reset_r;
  assign reset_vector_o = rst_vec_r;
  assign timeout_vector_o = tmo_vec_r;
  assign irq_o = |(ev_stat_r & ev_en_r);
endmodule // wcat_top

//--- dv/wcat_top_asserts.sv
`timescale 1ns/10ps
`include "wcat_defs.vh"
// ----
// port checks
// ----
module wcat_chk #(
  parameter TMO_BASE = 2048,
  parameter [15:0] BOOT_START = 16'h0c00
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire boot_reset_fuse_n_i,
  input wire vector_taken_i,
  input wire timeout_irq_req_o,
  input wire sys_reset_o,
  input wire [15:0] reset_vector_o,
  input wire [15:0] timeout_vector_o
);
  // shadows lag the design by one edge, so for one cycle after a clear they still over-claim
  wire wr_w = wb_ack_o && wb_we_i;
  reg cause_r;
  reg vts_r;
  always @(posedge clk_i) begin
    if (rst_i) begin
      cause_r <= 1'b0;
      vts_r <= 1'b0;
    end else begin
      if (sys_reset_o)
        cause_r <= 1'b1;
      else if (wr_w && wb_adr_i == `WCAT_ADR_CAUSE && !wb_dat_i[3])
        cause_r <= 1'b0;
      if (wr_w && wb_adr_i == `WCAT_ADR_CORE)
        vts_r <= wb_dat_i[1];
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_follows_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  reset_pulse_a: assert property (sys_reset_o |=> !sys_reset_o)
    else $error("system reset longer than one cycle");
  app_vector_a: assert property (boot_reset_fuse_n_i [*8] |-> reset_vector_o == `WCAT_VEC_RESET)
    else $error("reset vector not zero");
  boot_vector_a: assert property (!boot_reset_fuse_n_i [*8] |-> reset_vector_o == BOOT_START)
    else $error("reset vector not boot start");
  irq_vector_a: assert property ($stable(vts_r) [*6] |->
    timeout_vector_o == (vts_r ? `WCAT_VEC_WDT + BOOT_START : `WCAT_VEC_WDT)) else $error("bad timeout vector");
  cause_hold_a: assert property (wr_w == 1'b0 && wb_ack_o && wb_adr_i == `WCAT_ADR_CTRL && cause_r |-> wb_dat_o[3])
    else $error("reset enable read low with cause set");
  irq_taken_a: assert property (vector_taken_i |=> !timeout_irq_req_o)
    else $error("irq request kept after vector taken");
  reset_seen_c: cover property (sys_reset_o);
  irq_seen_c: cover property ($rose(timeout_irq_req_o));
  unlock_seen_c: cover property (wr_w && wb_adr_i == `WCAT_ADR_CTRL && wb_dat_i[4]);
endmodule // wcat_chk

bind wcat_top wcat_chk #(.TMO_BASE(TMO_BASE), .BOOT_START(BOOT_START)) i_wcat_chk (.*);

//--- dv/testbench.sv
`timescale 1ns/10ps
`include "wcat_defs.vh"
// ----
// bench
// ----
module testbench;
  // short base keeps the longest time-out at 2048 oscillator ticks
  localparam TMO_BASE = 4;
  localparam [15:0] BOOT_START = 16'h0c00;
  localparam [15:0] CODES = 16'h8510;
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg wb_cyc_i = 1'b0;
  reg wb_stb_i = 1'b0;
  reg wb_we_i = 1'b0;
  reg [7:0] wb_adr_i = 8'h00;
  reg [3:0] wb_sel_i = 4'hf;
  reg [31:0] wb_dat_i = 32'h0;
  reg wdt_osc_i = 1'b0;
  reg always_on_fuse_n_i = 1'b1;
  reg boot_reset_fuse_n_i = 1'b1;
  reg restart_i = 1'b0;
  reg vector_taken_i = 1'b0;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, timeout_irq_req_o, sys_reset_o, irq_o;
  wire [15:0] reset_vector_o, timeout_vector_o;
  reg [31:0] rdat;
  reg [3:0] c;
  reg [7:0] v;
  integer n_mismatch = 0;
  integer compares = 0;
  integer n_rst = 0;
  integer i;
  wcat_top #(.TMO_BASE(TMO_BASE), .BOOT_START(BOOT_START)) i_wcat_top (.*);
  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (sys_reset_o === 1'b1)
      n_rst <= n_rst + 1;
  end
  task results;
    begin
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  task chk(input [31:0] e, input [31:0] g, input string nm);
    begin
      compares = compares + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("wrong value %s: expected %h, seen %h", nm, e, g);
      end
    end
  endtask
  task bus(input w, input [7:0] a, input [31:0] d);
    integer k;
    begin
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      k = 0;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1 && k < 20) begin
        @(posedge clk_i);
        k = k + 1;
      end
      if (k == 20)
        chk(1, wb_ack_o, "ack");
      rdat = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [31:0] e, input string nm);
    begin
      bus(1'b0, a, 32'h0);
      chk(e, rdat, nm);
    end
  endtask
  // the new value must follow the unlock write inside the short window
  task unl(input [7:0] d);
    begin
      bus(1'b1, `WCAT_ADR_CTRL, 32'h18);
      bus(1'b1, `WCAT_ADR_CTRL, {24'h0, d});
    end
  endtask
  task tick(input integer t);
    begin
      repeat (t) begin
        repeat (6) @(posedge clk_i);
        wdt_osc_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        wdt_osc_i <= 1'b0;
      end
      repeat (8) @(posedge clk_i);
    end
  endtask
  task pulse(input r);
    begin
      @(posedge clk_i);
      if (r)
        restart_i <= 1'b1;
      else
        vector_taken_i <= 1'b1;
      @(posedge clk_i);
      restart_i <= 1'b0;
      vector_taken_i <= 1'b0;
      repeat (2) @(posedge clk_i);
    end
  endtask
  initial begin
    #400000;
    n_mismatch = n_mismatch + 1;
    results;
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`WCAT_ADR_CTRL, 32'h0, "ctrl");
    rd(`WCAT_ADR_CAUSE, 32'h0, "cause");
    rd(8'h1c, 32'h0, "unmapped");
    rd(`WCAT_ADR_VEC, {`WCAT_VEC_WDT, `WCAT_VEC_RESET}, "vectors");
    bus(1'b1, `WCAT_ADR_IEN, 32'h1);
    for (i = 0; i < 4; i = i + 1) begin
      c = CODES[i*4 +: 4];
      v = {2'b01, c[3], 2'b00, c[2:0]};
      unl(v);
      rd(`WCAT_ADR_CTRL, {24'h0, v}, "select");
      pulse(1'b1);
      tick((TMO_BASE << c) - 1);
      pulse(1'b1);
      tick((TMO_BASE << c) - 1);
      chk(0, timeout_irq_req_o, "early irq");
      tick(1);
      chk(1, timeout_irq_req_o, "timeout irq");
      pulse(1'b0);
      chk(0, timeout_irq_req_o, "taken irq");
    end
    chk(1, irq_o, "irq");
    bus(1'b1, `WCAT_ADR_IEN, 32'h0);
    chk(0, irq_o, "irq masked");
    rd(`WCAT_ADR_ISTAT, 32'h1, "status");
    bus(1'b1, `WCAT_ADR_IEN, 32'h1);
    bus(1'b1, `WCAT_ADR_ICLR, 32'h1);
    chk(0, irq_o, "irq cleared");
    bus(1'b1, `WCAT_ADR_CTRL, 32'h08);
    bus(1'b1, `WCAT_ADR_CTRL, 32'h01);
    rd(`WCAT_ADR_CTRL, 32'h28, "locked");
    bus(1'b1, `WCAT_ADR_CTRL, 32'h18);
    repeat (8) @(posedge clk_i);
    bus(1'b1, `WCAT_ADR_CTRL, 32'h01);
    rd(`WCAT_ADR_CTRL, 32'h28, "late change");
    unl(8'h08);
    pulse(1'b1);
    tick(TMO_BASE);
    chk(1, n_rst, "reset pulses");
    rd(`WCAT_ADR_CAUSE, 32'h08, "cause set");
    rd(`WCAT_ADR_ISTAT, 32'h2, "reset event");
    unl(8'h00);
    rd(`WCAT_ADR_CTRL, 32'h08, "forced enable");
    bus(1'b1, `WCAT_ADR_CAUSE, 32'h0);
    unl(8'h00);
    rd(`WCAT_ADR_CTRL, 32'h0, "disabled");
    tick(TMO_BASE);
    chk(1, n_rst, "stopped");
    unl(8'h48);
    pulse(1'b1);
    tick(TMO_BASE);
    chk(1, timeout_irq_req_o, "first timeout irq");
    chk(1, n_rst, "no reset on first");
    pulse(1'b0);
    rd(`WCAT_ADR_CTRL, 32'h08, "reset mode after vector");
    tick(TMO_BASE);
    chk(2, n_rst, "second timeout reset");
    bus(1'b1, `WCAT_ADR_CAUSE, 32'h0);
    unl(8'h00);
    rd(`WCAT_ADR_CTRL, 32'h0, "disabled again");
    bus(1'b1, `WCAT_ADR_CORE, 32'h2);
    repeat (4) @(posedge clk_i);
    rd(`WCAT_ADR_VEC, {`WCAT_VEC_WDT + BOOT_START, `WCAT_VEC_RESET}, "moved");
    boot_reset_fuse_n_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    rd(`WCAT_ADR_VEC, {`WCAT_VEC_WDT + BOOT_START, BOOT_START}, "boot");
    always_on_fuse_n_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    rd(`WCAT_ADR_CTRL, 32'h08, "always on");
    results;
  end
endmodule // testbench
